// File: pif_adapter.sv
// Dual 8-bit parallel port adapter: register file, ports, interrupts.
// Assumes host bus and peripheral inputs are synchronous to clk,
// and that wire levels are resolved outside from the enables.
`timescale 1ns/1ps
`include "pif_consts.svh"

module pif_adapter import pif_pkg::*; (
  input wire logic clk,  // Core clock, 250 MHz
  input wire logic rst_n,  // Async reset, low
  input wire logic strobe,  // Enable strobe
  input wire logic select_high_first,  // Chip select, high
  input wire logic select_high_second,  // Chip select, high
  input wire logic select_low,  // Chip select, low
  input wire logic read_not_write,  // 1 = read
  input wire logic reg_select_high,  // Register select bit 1
  input wire logic reg_select_low,  // Register select bit 0
  input wire logic [`PIF_DW-1:0] data_in,  // Host data in
  output logic [`PIF_DW-1:0] data_out,  // Host data out
  output logic data_oe_n,  // Host data enable, low
  input wire logic [`PIF_DW-1:0] port_a_lines_in,  // Port A pins
  output logic [`PIF_DW-1:0] port_a_lines_out,  // Port A drive
  output logic [`PIF_DW-1:0] port_a_lines_oe_n,  // Port A enable, low
  input wire logic [`PIF_DW-1:0] port_b_lines_in,  // Port B pins
  output logic [`PIF_DW-1:0] port_b_lines_out,  // Port B drive
  output logic [`PIF_DW-1:0] port_b_lines_oe_n,  // Port B enable, low
  input wire logic a_edge_input,  // Port A edge input
  input wire logic b_edge_input,  // Port B edge input
  input wire logic a_config_line_in,  // Port A config pin
  output logic a_config_line_out,  // Port A config drive
  output logic a_config_line_oe_n,  // Port A config enable, low
  input wire logic b_config_line_in,  // Port B config pin
  output logic b_config_line_out,  // Port B config drive
  output logic b_config_line_oe_n,  // Port B config enable, low
  input wire logic a_irq_n_in,  // Shared irq wire level
  output logic a_irq_n_out,  // Irq A drive level
  output logic a_irq_n_oe_n,  // Irq A pull-down, low
  input wire logic b_irq_n_in,  // Shared irq wire level
  output logic b_irq_n_out,  // Irq B drive level
  output logic b_irq_n_oe_n  // Irq B pull-down, low
);

  // ****************************************
  // Bus front end
  // ****************************************
  logic [1:0] sel_rs;  // Latched register select
  logic rd_window;  // Read in progress
  logic wr_pulse;  // Write strobe end
  logic rd_done;  // Read strobe end
  logic desel_strobe;  // Deselected strobe end
  logic strobe_fall;  // Any strobe end

  pif_bus_front u_front (
    .clk(clk),
    .rst_n(rst_n),
    .strobe(strobe),
    .select_high_first(select_high_first),
    .select_high_second(select_high_second),
    .select_low(select_low),
    .read_not_write(read_not_write),
    .reg_select_high(reg_select_high),
    .reg_select_low(reg_select_low),
    .sel_rs(sel_rs),
    .rd_window(rd_window),
    .wr_pulse(wr_pulse),
    .rd_done(rd_done),
    .desel_strobe(desel_strobe),
    .strobe_fall(strobe_fall)
  );

  // ****************************************
  // Per-port storage and interrupt logic
  // ****************************************
  logic [`PIF_DW-1:0] out_reg [2];  // Output registers
  logic [`PIF_DW-1:0] ddr [2];  // Direction registers
  logic [`PIF_CTL_W-1:0] ctl [2];  // Writable control bits
  logic [`PIF_DW-1:0] pin_in [2];  // Pin levels
  logic [`PIF_DW-1:0] readback [2];  // Data read value
  logic [`PIF_DW-1:0] ctl_word [2];  // Control read value
  logic [1:0] edge_in;  // Edge inputs
  logic [1:0] cfg_in;  // Config line levels
  logic [1:0] flag_edge;  // Edge input flags
  logic [1:0] flag_cfg;  // Config line flags
  logic [1:0] clear_flags;  // Flag clear per port
  logic [1:0] irq_req;  // Irq wanted per port

  assign pin_in[0] = port_a_lines_in;
  assign pin_in[1] = port_b_lines_in;
  assign edge_in = {b_edge_input, a_edge_input};
  assign cfg_in = {b_config_line_in, a_config_line_in};

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [1:0] DATA_SEL = (p == 0) ? `PIF_SEL_A_DATA : `PIF_SEL_B_DATA;
    localparam logic [1:0] CTL_SEL = (p == 0) ? `PIF_SEL_A_CTL : `PIF_SEL_B_CTL;
    logic data_hit;  // Data or direction slot selected
    logic ctl_hit;  // Control slot selected
    logic access;  // Access bit picks data register

    assign data_hit = (sel_rs == DATA_SEL);
    assign ctl_hit = (sel_rs == CTL_SEL);
    assign access = ctl[p][`PIF_CTL_DATA_ACCESS];

    // Output register
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        out_reg[p] <= `PIF_RESET_BYTE;
      end else if (wr_pulse && data_hit && access) begin
        out_reg[p] <= data_in;
      end
    end

    // Direction register
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ddr[p] <= `PIF_RESET_BYTE;
      end else if (wr_pulse && data_hit && !access) begin
        ddr[p] <= data_in;
      end
    end

    // Control register, flag bits are not writable
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl[p] <= `PIF_RESET_CTL;
      end else if (wr_pulse && ctl_hit) begin
        ctl[p] <= data_in[`PIF_CTL_W-1:0];
      end
    end

    // Only a completed read of the data register (access bit set) clears; a direction read does not
    assign clear_flags[p] = rd_done & data_hit & access;

    pif_edge_sense u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .line(edge_in[p]),
      .rise_sel(ctl[p][`PIF_CTL_EDGE_RISE]),
      .allowed(1'b1),
      .strobe_fall(strobe_fall),
      .desel_strobe(desel_strobe),
      .clear(clear_flags[p]),
      .flag(flag_edge[p])
    );

    pif_edge_sense u_cfg (
      .clk(clk),
      .rst_n(rst_n),
      .line(cfg_in[p]),
      .rise_sel(ctl[p][`PIF_CTL_CFG_RISE]),
      .allowed(!ctl[p][`PIF_CTL_CFG_OUT]),
      .strobe_fall(strobe_fall),
      .desel_strobe(desel_strobe),
      .clear(clear_flags[p]),
      .flag(flag_cfg[p])
    );

    // Each output sees two flags, each with its own enable
    assign irq_req[p] = (flag_edge[p] & ctl[p][`PIF_CTL_EDGE_IRQ_EN])
      | (flag_cfg[p] & ctl[p][`PIF_CTL_CFG_IRQ_EN] & ~ctl[p][`PIF_CTL_CFG_OUT]);

    assign ctl_word[p] = {flag_edge[p], flag_cfg[p], ctl[p]};

    if (p == 0) begin : g_pin_read
      // Port A reads the pin even where driven
      assign readback[p] = pin_in[p];
    end else begin : g_latch_read
      // Port B reads its latch where driven
      assign readback[p] = (ddr[p] & out_reg[p]) | (~ddr[p] & pin_in[p]);
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  logic [`PIF_DW-1:0] rd_mux;  // Selected register value

  always_comb begin
    if (sel_rs == `PIF_SEL_A_DATA) begin
      rd_mux = ctl[0][`PIF_CTL_DATA_ACCESS] ? readback[0] : ddr[0];
    end else if (sel_rs == `PIF_SEL_A_CTL) begin
      rd_mux = ctl_word[0];
    end else if (sel_rs == `PIF_SEL_B_DATA) begin
      rd_mux = ctl[1][`PIF_CTL_DATA_ACCESS] ? readback[1] : ddr[1];
    end else begin
      rd_mux = ctl_word[1];
    end
  end

  // ****************************************
  // Host data bus drive
  // ****************************************
  logic drv;  // Bus driven this cycle

  // One cycle behind rd_window, two behind the strobe; the host samples late in the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv <= 1'b0;
      data_out <= `PIF_RESET_BYTE;
    end else begin
      drv <= rd_window;
      data_out <= rd_window ? rd_mux : `PIF_RESET_BYTE;
    end
  end

  assign data_oe_n = ~drv;

  // ****************************************
  // Peripheral pin drive
  // ****************************************
  assign port_a_lines_out = out_reg[0];
  assign port_b_lines_out = out_reg[1];
  assign port_a_lines_oe_n = ~ddr[0];
  assign port_b_lines_oe_n = ~ddr[1];

  // Output mode shows only the static level; pulse modes are not built
  assign a_config_line_out = ctl[0][`PIF_CTL_CFG_LEVEL];
  assign b_config_line_out = ctl[1][`PIF_CTL_CFG_LEVEL];
  assign a_config_line_oe_n = ~ctl[0][`PIF_CTL_CFG_OUT];
  assign b_config_line_oe_n = ~ctl[1][`PIF_CTL_CFG_OUT];

  // Open drain: level is always low, enable pulls or floats
  assign a_irq_n_out = 1'b0;
  assign b_irq_n_out = 1'b0;
  assign a_irq_n_oe_n = ~irq_req[0];
  assign b_irq_n_oe_n = ~irq_req[1];

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bus_float;
    !data_oe_n |-> $past(rd_window);
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus driven outside read");

  property p_ctl_write;
    wr_pulse && sel_rs == `PIF_SEL_A_CTL |=> ctl[0] == $past(data_in[`PIF_CTL_W-1:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  property p_dir_write;
    wr_pulse && sel_rs == `PIF_SEL_A_DATA && !ctl[0][`PIF_CTL_DATA_ACCESS]
      |=> port_a_lines_oe_n == ~$past(data_in);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied");

  sequence s_b_read;
    rd_window && sel_rs == `PIF_SEL_B_DATA && ctl[1][`PIF_CTL_DATA_ACCESS];
  endsequence

  property p_b_latch_read;
    s_b_read |=> data_out == (($past(ddr[1]) & $past(out_reg[1]))
      | (~$past(ddr[1]) & $past(port_b_lines_in)));
  endproperty
  a_b_latch_read: assert property (p_b_latch_read) else $error("port B readback wrong");

  property p_irq_follow;
    $rose(flag_edge[0]) && ctl[0][`PIF_CTL_EDGE_IRQ_EN] |-> !a_irq_n_oe_n;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq A not asserted");

endmodule

// File: pif_consts.svh
// Named constants for the dual parallel port adapter.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define PIF_DW 8
`define PIF_CTL_W 6
`define PIF_RESET_BYTE 8'h00
`define PIF_RESET_CTL 6'h00

// ****************************************
// Register select codes
// ****************************************
`define PIF_SEL_A_DATA 2'h0
`define PIF_SEL_A_CTL 2'h1
`define PIF_SEL_B_DATA 2'h2
`define PIF_SEL_B_CTL 2'h3

// ****************************************
// Control register bit positions
// ****************************************
`define PIF_CTL_EDGE_IRQ_EN 0
`define PIF_CTL_EDGE_RISE 1
`define PIF_CTL_DATA_ACCESS 2
`define PIF_CTL_CFG_IRQ_EN 3
`define PIF_CTL_CFG_LEVEL 3
`define PIF_CTL_CFG_RISE 4
`define PIF_CTL_CFG_OUT 5

`endif

// File: pif_pkg.sv
// Shared types for the dual parallel port adapter.
// Assumes nothing beyond a SystemVerilog compiler.
package pif_pkg;

  // ****************************************
  // Bus strobe tracking states
  // ****************************************
  typedef enum logic [1:0] {
    PIF_ST_IDLE = 2'b01,  // Strobe low, waiting
    PIF_ST_STROBE = 2'b10  // Strobe high, cycle in progress
  } pif_bus_state_t;

endpackage

// File: pif_edge_sense.sv
// Edge sense network and sticky flag for one interrupt line.
// Assumes line and strobe events are synchronous to clk.
`timescale 1ns/1ps
module pif_edge_sense (
  input wire logic clk,  // Core clock
  input wire logic rst_n,  // Async reset, low
  input wire logic line,  // Interrupt input level
  input wire logic rise_sel,  // 1 = low-to-high is active
  input wire logic allowed,  // Line is in input mode
  input wire logic strobe_fall,  // End of any strobe
  input wire logic desel_strobe,  // End of a deselected strobe
  input wire logic clear,  // Data read clears the flag
  output logic flag  // Sticky flag
);

  // ****************************************
  // Edge detection
  // ****************************************
  logic line_q;  // Previous level
  logic cond;  // Network conditioned by a strobe
  logic armed;  // Flag may set again
  logic act_now;  // Line at active level
  logic act_prev;  // Line was at active level
  logic act_edge;  // Active transition now
  logic set_ev;  // Flag set event

  assign act_now = rise_sel ? line : ~line;
  assign act_prev = rise_sel ? line_q : ~line_q;
  assign act_edge = act_now & ~act_prev;
  // Old armed value is used, so a set on the clearing cycle still lands
  assign set_ev = act_edge & cond & armed & allowed;

  // Level history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line;
    end
  end

  // Conditioning needs a strobe seen at the inactive level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond <= 1'b0;
    end else if (strobe_fall && !act_now) begin
      cond <= 1'b1;
    end else if (act_edge) begin
      cond <= 1'b0;  // Used up by this edge
    end
  end

  // Re-arm only through a deselected strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (clear) begin
      armed <= 1'b0;
    end else if (desel_strobe) begin
      armed <= 1'b1;
    end
  end

  // Sticky flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= set_ev | (flag & ~clear);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_clear_flag;
    clear && !set_ev |=> !flag;
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("flag survived clear");

  property p_disarm;
    clear ##1 !desel_strobe |-> !armed && !set_ev;
  endproperty
  a_disarm: assert property (p_disarm) else $error("flag set before re-arm");

endmodule

// File: pif_bus_front.sv
// Host bus front end: strobe edges, selection and cycle pulses.
// Assumes all host bus inputs are synchronous to clk.
`timescale 1ns/1ps
`include "pif_consts.svh"
module pif_bus_front import pif_pkg::*; (
  input wire logic clk,  // Core clock
  input wire logic rst_n,  // Async reset, low
  input wire logic strobe,  // Enable strobe
  input wire logic select_high_first,  // Chip select, high
  input wire logic select_high_second,  // Chip select, high
  input wire logic select_low,  // Chip select, low
  input wire logic read_not_write,  // 1 = read
  input wire logic reg_select_high,  // Register select bit 1
  input wire logic reg_select_low,  // Register select bit 0
  output logic [1:0] sel_rs,  // Latched register select
  output logic rd_window,  // Selected read in progress
  output logic wr_pulse,  // Write at strobe fall
  output logic rd_done,  // Read at strobe fall
  output logic desel_strobe,  // Deselected strobe ended
  output logic strobe_fall  // Any strobe ended
);

  // ****************************************
  // Strobe tracking
  // ****************************************
  pif_bus_state_t state;  // Cycle state
  logic strobe_q;  // Previous strobe
  logic rise;  // Strobe leading edge
  logic fall;  // Strobe trailing edge
  logic selected;  // All chip selects active
  logic sel_q;  // Selection at leading edge
  logic rw_q;  // Direction at leading edge

  assign rise = strobe & ~strobe_q;
  assign fall = ~strobe & strobe_q;
  assign selected = select_high_first & select_high_second & ~select_low;

  // Strobe history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
    end
  end

  // Cycle state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PIF_ST_IDLE;
    end else begin
      case (state)
        PIF_ST_IDLE: begin
          if (rise) begin
            state <= PIF_ST_STROBE;
          end
        end
        PIF_ST_STROBE: begin
          if (fall) begin
            state <= PIF_ST_IDLE;
          end
        end
        default: begin
          state <= PIF_ST_IDLE;
        end
      endcase
    end
  end

  // Host holds selects stable, so the leading edge value is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      rw_q <= 1'b0;
      sel_rs <= `PIF_SEL_A_DATA;
    end else if (rise) begin
      sel_q <= selected;
      rw_q <= read_not_write;
      sel_rs <= {reg_select_high, reg_select_low};
    end
  end

  assign strobe_fall = fall & (state == PIF_ST_STROBE);
  assign rd_window = (state == PIF_ST_STROBE) & sel_q & rw_q;
  assign wr_pulse = strobe_fall & sel_q & ~rw_q;
  assign rd_done = strobe_fall & sel_q & rw_q;
  assign desel_strobe = strobe_fall & ~sel_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_desel_quiet;
    rise && !selected |=> (!wr_pulse && !rd_done) [*2];
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("access while deselected");

  property p_write_at_fall;
    wr_pulse |-> !strobe && $past(strobe);
  endproperty
  a_write_at_fall: assert property (p_write_at_fall) else $error("write off strobe edge");

endmodule

// File: pif_host_model.sv
// Host bus master model for the dual parallel port adapter.
// Assumes the bench calls cycle() from a process that follows clk.
`timescale 1ns/1ps
module pif_host_model (
  input wire logic clk,  // Core clock
  input wire logic [7:0] data_out,  // Device read data
  input wire logic data_oe_n,  // Device drive enable, low
  output logic strobe,  // Enable strobe
  output logic [2:0] cs,  // Selects: high, high, low
  output logic read_not_write,  // 1 = read
  output logic [1:0] rs,  // Register select
  output logic [7:0] data_in  // Host write data
);
  // ****************************************
  // Idle bus: deselected, strobe low
  // ****************************************
  initial begin
    strobe = 1'h0;
    cs = 3'h1;  // Low select high, so deselected
    read_not_write = 1'h1;
    rs = 2'h0;
    data_in = 8'h00;
  end

  // One strobe cycle; everything held until the fall edge has been taken
  task automatic cycle(input logic [2:0] sel, input logic rd, input logic [1:0] r,
                       input logic [7:0] wd, output logic [7:0] rv, output logic oe);
    @(posedge clk);
    strobe <= 1'h1;
    cs <= sel;
    read_not_write <= rd;
    rs <= r;
    data_in <= wd;
    // Read data is registered one clock after the leading edge is seen
    repeat (2) @(posedge clk);
    @(negedge clk);
    rv = data_out;
    oe = data_oe_n;
    @(posedge clk);
    strobe <= 1'h0;
    @(posedge clk);
    cs <= 3'h1;
    // Released bus shows no stale value
    data_in <= ~wd;
    // Trailing edge results settle before the caller looks at them
    @(negedge clk);
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the dual parallel port adapter.
// Assumes pif_adapter and pif_host_model are compiled before it.
`timescale 1ns/1ps
module testbench import pif_pkg::*;;
  typedef struct packed {logic [2:0] cs; logic rd; logic [1:0] rs; logic [7:0] d;} pif_row_t;
  localparam logic [7:0] A_EXT = 8'h3C;  // Far-end level on port A inputs
  localparam logic [7:0] A_LOAD = 8'h80;  // Heavy load flips this pin
  localparam logic [7:0] B_EXT = 8'hC3;  // Far-end level on port B inputs
  logic clk = 1'h0, rst_n = 1'h0, strobe, rnw, a_edge = 1'h0, b_edge = 1'h0;
  logic a_cfg_ext = 1'h1;  // Far-end level on config line A, idles high
  logic [2:0] cs;
  logic [1:0] rs;
  logic [7:0] hdata, data_out, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, rv;
  logic data_oe_n, oe, a_ci, a_co, a_coe, b_ci, b_co, b_coe, a_io, a_ioe, b_io, b_ioe, irq;
  int fails = 0, checked = 0;
  // Rows: selects, read, register select, write data or expected read
  pif_row_t rows[19] = '{{3'h6,1'h0,2'h1,8'h00}, {3'h6,1'h0,2'h0,8'hF0}, {3'h6,1'h1,2'h0,8'hF0},
    {3'h6,1'h0,2'h3,8'h00}, {3'h6,1'h0,2'h2,8'h0F}, {3'h6,1'h1,2'h2,8'h0F},
    {3'h2,1'h0,2'h0,8'hFF}, {3'h4,1'h0,2'h0,8'hFF}, {3'h7,1'h0,2'h0,8'hFF},
    {3'h6,1'h1,2'h0,8'hF0}, {3'h2,1'h1,2'h0,8'h00}, {3'h6,1'h0,2'h1,8'h3F},
    {3'h6,1'h1,2'h1,8'h3F}, {3'h6,1'h0,2'h3,8'hFF}, {3'h6,1'h1,2'h3,8'h3F},
    {3'h6,1'h0,2'h0,8'hA5}, {3'h6,1'h1,2'h0,8'h2C}, {3'h6,1'h0,2'h2,8'h5A},
    {3'h6,1'h1,2'h2,8'hCA}};

  always #2 clk = ~clk;
  // Pin resolution: port A output pins see a load, port B outputs are overdriven
  assign a_in = (a_oe_n & A_EXT) | (~a_oe_n & (a_out ^ A_LOAD));
  assign b_in = (b_oe_n & B_EXT) | (~b_oe_n & ~b_out);
  assign a_ci = a_coe ? a_cfg_ext : a_co;
  assign b_ci = b_coe ? 1'h1 : b_co;
  // Shared request wire with pull-up
  assign irq = (a_ioe | a_io) & (b_ioe | b_io);

  pif_host_model pif_host_model_inst (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .strobe(strobe), .cs(cs), .read_not_write(rnw), .rs(rs), .data_in(hdata));
  pif_adapter pif_adapter_inst (.clk(clk), .rst_n(rst_n), .strobe(strobe),
    .select_high_first(cs[2]), .select_high_second(cs[1]), .select_low(cs[0]),
    .read_not_write(rnw), .reg_select_high(rs[1]), .reg_select_low(rs[0]), .data_in(hdata),
    .data_out(data_out), .data_oe_n(data_oe_n), .port_a_lines_in(a_in),
    .port_a_lines_out(a_out), .port_a_lines_oe_n(a_oe_n), .port_b_lines_in(b_in),
    .port_b_lines_out(b_out), .port_b_lines_oe_n(b_oe_n), .a_edge_input(a_edge),
    .b_edge_input(b_edge), .a_config_line_in(a_ci), .a_config_line_out(a_co),
    .a_config_line_oe_n(a_coe), .b_config_line_in(b_ci), .b_config_line_out(b_co),
    .b_config_line_oe_n(b_coe), .a_irq_n_in(irq), .a_irq_n_out(a_io), .a_irq_n_oe_n(a_ioe),
    .b_irq_n_in(irq), .b_irq_n_out(b_io), .b_irq_n_oe_n(b_ioe));

  // ****************************************
  // Compare, access, edge and closing helpers
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic acc(input logic [2:0] c, input logic rd, input logic [1:0] r,
                     input logic [7:0] d);
    pif_host_model_inst.cycle(c, rd, r, d, rv, oe);
  endtask

  // Edge input A moves, then the flag has two edges to land
  task automatic edge_a(input logic v);
    @(posedge clk);
    a_edge <= v;
    repeat (2) @(posedge clk);
  endtask

  task automatic finish_test;
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    chk("oe in reset", {data_oe_n, a_oe_n[0], b_oe_n[7], a_coe, b_coe, a_ioe, b_ioe, 1'h1}, 8'hFF);
    rst_n <= 1'h1;
    // Table rows: decode, direction, selects, read-only flags, port readback
    foreach (rows[i]) begin
      acc(rows[i].cs, rows[i].rd, rows[i].rs, rows[i].d);
      chk("data_oe_n", {7'h0, oe}, {7'h0, ~(rows[i].rd && rows[i].cs == 3'h6)});
      if (rows[i].rd && rows[i].cs == 3'h6) chk("read data", rv, rows[i].d);
    end
    chk("a pins", a_out, 8'hA5);
    chk("a enables", a_oe_n, 8'h0F);
    chk("b enables", b_oe_n, 8'hF0);
    chk("cfg lines", {4'h0, a_coe, a_co, b_coe, b_co}, 8'h05);
    // Edge interrupt on port A: enable, rising edge, data access
    acc(3'h6, 1'h0, 2'h1, 8'h07);
    acc(3'h0, 1'h0, 2'h0, 8'h00);
    edge_a(1'h1);
    chk("irq a set", {7'h0, a_ioe}, 8'h00);
    chk("irq wire", {7'h0, irq}, 8'h00);
    acc(3'h6, 1'h1, 2'h1, 8'h00);
    chk("ctl a flag", rv, 8'h87);
    acc(3'h6, 1'h0, 2'h1, 8'h06);
    chk("irq a masked", {7'h0, a_ioe}, 8'h01);
    acc(3'h6, 1'h0, 2'h1, 8'h07);
    chk("irq a unmasked", {7'h0, a_ioe}, 8'h00);
    acc(3'h6, 1'h1, 2'h0, 8'h00);
    chk("irq a cleared", {7'h0, a_ioe}, 8'h01);
    edge_a(1'h0);
    acc(3'h6, 1'h1, 2'h1, 8'h00);
    chk("ctl a cleared", rv, 8'h07);
    edge_a(1'h1);
    chk("no rearm", {7'h0, a_ioe}, 8'h01);
    edge_a(1'h0);
    acc(3'h1, 1'h0, 2'h0, 8'h00);
    edge_a(1'h1);
    chk("rearmed", {7'h0, a_ioe}, 8'h00);
    // Config line A as falling-edge input, edge input B raises request B
    acc(3'h6, 1'h1, 2'h0, 8'h00);
    acc(3'h1, 1'h0, 2'h0, 8'h00);
    acc(3'h6, 1'h0, 2'h1, 8'h0F);
    @(posedge clk);
    a_cfg_ext <= 1'h0;
    b_edge <= 1'h1;
    repeat (2) @(posedge clk);
    chk("irq both", {6'h0, a_ioe, b_ioe}, 8'h00);
    acc(3'h6, 1'h1, 2'h1, 8'h00);
    chk("ctl a cfg flag", rv, 8'h4F);
    acc(3'h6, 1'h1, 2'h3, 8'h00);
    chk("ctl b flag", rv, 8'hBF);
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk("oe mid reset", {a_oe_n[3:0], b_oe_n[3:0]}, 8'hFF);
    chk("irq mid reset", {5'h0, b_ioe, a_ioe, a_coe}, 8'h07);
    rst_n <= 1'h1;
    acc(3'h6, 1'h1, 2'h1, 8'h00);
    chk("ctl a reset", rv, 8'h00);
    finish_test;
  end
endmodule
